//--- shared/adcsm_pkg.sv
package adcsm_pkg;

	// register command port
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [ADDR_W-1:0] ADDR_CONDITION_FLAGS = 5'h01;
	localparam logic [ADDR_W-1:0] ADDR_INPUT_SELECTOR  = 5'h02;

	// reset values
	localparam logic [DATA_W-1:0] RST_INPUT_SELECTOR = 8'h01;
	localparam logic              RST_POWER_ON_FLAG  = 1'b1;
	localparam logic              RST_NOT_READY      = 1'b0;
	localparam logic [3:0]        RST_RAIL_FLAGS     = 4'h0;
	localparam logic [1:0]        RST_REF_FLAGS      = 2'h0;
	localparam logic [DATA_W-1:0] RD_DATA_IDLE       = 8'h00;

	// condition flag bit positions
	localparam int BIT_POWER_ON    = 7;
	localparam int BIT_NOT_READY   = 6;
	localparam int BIT_RAIL_MSB    = 5;
	localparam int BIT_RAIL_LSB    = 2;
	localparam int BIT_REF_THIRD   = 1;
	localparam int BIT_REF_MISSING = 0;

	// input selector fields
	localparam int POS_SEL_MSB = 7;
	localparam int POS_SEL_LSB = 4;
	localparam int NEG_SEL_MSB = 3;
	localparam int NEG_SEL_LSB = 0;

	// input selection codes
	localparam logic [3:0] CODE_LAST_SIX    = 4'h5;
	localparam logic [3:0] CODE_LAST_TWELVE = 4'hb;
	localparam logic [3:0] CODE_COMMON      = 4'hc;

	// reference monitor enable field
	localparam int REF_EN_THIRD_BIT = 1;

	// raw level vector layout, as it enters the synchroniser
	localparam int RAW_W           = 9;
	localparam int RAW_POWER_ON    = 8;
	localparam int RAW_NOT_READY   = 7;
	localparam int RAW_RAIL_MSB    = 6;
	localparam int RAW_RAIL_LSB    = 3;
	localparam int RAW_REF_THIRD   = 2;
	localparam int RAW_REF_MISSING = 1;
	localparam int RAW_TWELVE_CH   = 0;
	localparam logic [RAW_W-1:0] RST_RAW = 9'h000;

endpackage : adcsm_pkg

//--- design/adcsm_regs.sv
// Overview of operation
// - power-on flag sets on reset, host clears
// - bit 6 high while start-up pending
// - bit 5: positive output near top rail
// - bit 4: positive output near bottom rail
// - bit 3: negative output near top rail
// - bit 2: negative output near bottom rail
// - bit 1: reference below third of span
// - bit 0: reference missing below low threshold
// - rail flags only while rail monitor enabled
// - reference flags only as field enables
// - bits 7:4 positive select, reset 0000
// - bits 3:0 negative select, reset 0001
// - codes six to eleven need twelve channels
// - reached only by register commands; reset restores
`timescale 1ns/1ps

module adcsm_regs (
	input  wire logic                           clk,
	input  wire logic                           reset,
	// register command port from the serial engine
	input  wire logic                           cmd_read,
	input  wire logic                           cmd_write,
	input  wire logic [adcsm_pkg::ADDR_W-1:0]   cmd_addr,
	input  wire logic [adcsm_pkg::DATA_W-1:0]   cmd_wdata,
	output logic      [adcsm_pkg::DATA_W-1:0]   rd_data,
	output logic                                rd_valid,
	// enables held in neighbouring registers, same clock
	input  wire logic                           rail_monitor_enable,
	input  wire logic [1:0]                     reference_monitor_enable,
	// analog and supervisor levels, asynchronous
	input  wire logic                           power_on_event_raw,
	input  wire logic                           startup_pending_raw,
	input  wire logic                           pos_out_near_top_rail_raw,
	input  wire logic                           pos_out_near_bottom_rail_raw,
	input  wire logic                           neg_out_near_top_rail_raw,
	input  wire logic                           neg_out_near_bottom_rail_raw,
	input  wire logic                           reference_below_third_raw,
	input  wire logic                           reference_missing_raw,
	input  wire logic                           twelve_channel_strap,
	// converter input selection and the power-on flag
	output logic      [3:0]                     positive_input_select,
	output logic      [3:0]                     negative_input_select,
	output logic                                positive_select_valid,
	output logic                                negative_select_valid,
	output logic                                power_on_event_flag
);

	logic [adcsm_pkg::RAW_W-1:0]  raw_vec;
	logic [adcsm_pkg::RAW_W-1:0]  sync_meta_reg;
	logic [adcsm_pkg::RAW_W-1:0]  sync_reg;
	logic                         not_ready_reg;
	logic [3:0]                   rail_flags_reg;
	logic [1:0]                   ref_flags_reg;
	logic [adcsm_pkg::DATA_W-1:0] input_selector_reg;
	logic [adcsm_pkg::DATA_W-1:0] input_selector_next;
	logic [adcsm_pkg::DATA_W-1:0] condition_byte;
	logic                         hit_flags;
	logic                         hit_selector;
	logic                         por_clear;
	logic                         por_seen;
	logic                         twelve_ch;

	// true when a selection code names an input that exists on this variant
	function automatic logic code_exists(input logic [3:0] code, input logic twelve);
		logic ok;
		ok = 1'b0;
		if (code <= adcsm_pkg::CODE_LAST_SIX) begin
			ok = 1'b1;
		end else if (code <= adcsm_pkg::CODE_LAST_TWELVE) begin
			ok = twelve;
		end else if (code == adcsm_pkg::CODE_COMMON) begin
			ok = 1'b1;
		end
		return ok;
	endfunction : code_exists

	assign raw_vec = {power_on_event_raw,
		startup_pending_raw,
		pos_out_near_top_rail_raw,
		pos_out_near_bottom_rail_raw,
		neg_out_near_top_rail_raw,
		neg_out_near_bottom_rail_raw,
		reference_below_third_raw,
		reference_missing_raw,
		twelve_channel_strap};

	// all asynchronous levels pass two flops before use
	always_ff @(posedge clk) begin
		if (reset) begin
			sync_meta_reg <= adcsm_pkg::RST_RAW;
			sync_reg      <= adcsm_pkg::RST_RAW;
		end else begin
			sync_meta_reg <= raw_vec;
			sync_reg      <= sync_meta_reg;
		end
	end

	assign por_seen  = sync_reg[adcsm_pkg::RAW_POWER_ON];
	assign twelve_ch = sync_reg[adcsm_pkg::RAW_TWELVE_CH];

	assign hit_flags    = (cmd_addr == adcsm_pkg::ADDR_CONDITION_FLAGS);
	assign hit_selector = (cmd_addr == adcsm_pkg::ADDR_INPUT_SELECTOR);

	// a written 0 clears; a written 1 leaves the flag alone
	assign por_clear = cmd_write && hit_flags && !cmd_wdata[adcsm_pkg::BIT_POWER_ON];

	// set wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			power_on_event_flag <= adcsm_pkg::RST_POWER_ON_FLAG;
		end else if (por_seen) begin
			power_on_event_flag <= 1'b1;
		end else if (por_clear) begin
			power_on_event_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			not_ready_reg <= adcsm_pkg::RST_NOT_READY;
		end else begin
			not_ready_reg <= sync_reg[adcsm_pkg::RAW_NOT_READY];
		end
	end

	// live monitors, gated by their enables; they follow the comparators, not sticky
	always_ff @(posedge clk) begin
		if (reset) begin
			rail_flags_reg <= adcsm_pkg::RST_RAIL_FLAGS;
			ref_flags_reg  <= adcsm_pkg::RST_REF_FLAGS;
		end else begin
			rail_flags_reg <= sync_reg[adcsm_pkg::RAW_RAIL_MSB:adcsm_pkg::RAW_RAIL_LSB]
				& {4{rail_monitor_enable}};
			ref_flags_reg[1] <= sync_reg[adcsm_pkg::RAW_REF_THIRD]
				& reference_monitor_enable[adcsm_pkg::REF_EN_THIRD_BIT];
			ref_flags_reg[0] <= sync_reg[adcsm_pkg::RAW_REF_MISSING]
				& (|reference_monitor_enable);
		end
	end

	assign condition_byte = {power_on_event_flag, not_ready_reg, rail_flags_reg, ref_flags_reg};

	always_comb begin
		input_selector_next = input_selector_reg;
		if (cmd_write && hit_selector) begin
			input_selector_next = cmd_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			input_selector_reg <= adcsm_pkg::RST_INPUT_SELECTOR;
		end else begin
			input_selector_reg <= input_selector_next;
		end
	end

	// field outputs and validity share one edge so they always agree
	always_ff @(posedge clk) begin
		if (reset) begin
			positive_input_select <= adcsm_pkg::RST_INPUT_SELECTOR[adcsm_pkg::POS_SEL_MSB:
				adcsm_pkg::POS_SEL_LSB];
			negative_input_select <= adcsm_pkg::RST_INPUT_SELECTOR[adcsm_pkg::NEG_SEL_MSB:
				adcsm_pkg::NEG_SEL_LSB];
			positive_select_valid <= 1'b1;
			negative_select_valid <= 1'b1;
		end else begin
			positive_input_select <= input_selector_next[adcsm_pkg::POS_SEL_MSB:
				adcsm_pkg::POS_SEL_LSB];
			negative_input_select <= input_selector_next[adcsm_pkg::NEG_SEL_MSB:
				adcsm_pkg::NEG_SEL_LSB];
			positive_select_valid <= code_exists(
				input_selector_next[adcsm_pkg::POS_SEL_MSB:adcsm_pkg::POS_SEL_LSB],
				twelve_ch);
			negative_select_valid <= code_exists(
				input_selector_next[adcsm_pkg::NEG_SEL_MSB:adcsm_pkg::NEG_SEL_LSB],
				twelve_ch);
		end
	end

	// snapshot at the command edge so one read is one coherent byte
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_data  <= adcsm_pkg::RD_DATA_IDLE;
			rd_valid <= 1'b0;
		end else if (cmd_read && hit_flags) begin
			rd_data  <= condition_byte;
			rd_valid <= 1'b1;
		end else if (cmd_read && hit_selector) begin
			rd_data  <= input_selector_reg;
			rd_valid <= 1'b1;
		end else begin
			rd_data  <= adcsm_pkg::RD_DATA_IDLE;
			rd_valid <= 1'b0;
		end
	end

	// checks

	sequence flags_read_s;
		cmd_read && hit_flags;
	endsequence

	sequence por_clear_only_s;
		por_clear && !por_seen;
	endsequence

	por_set_wins_a: assert property (@(posedge clk) disable iff (reset)
		por_seen |=> power_on_event_flag)
		else $error("power-on flag not set by event");

	por_clear_a: assert property (@(posedge clk) disable iff (reset)
		por_clear_only_s |=> !power_on_event_flag)
		else $error("power-on flag not cleared by write of zero");

	por_holds_a: assert property (@(posedge clk) disable iff (reset)
		power_on_event_flag && !por_clear |=> power_on_event_flag)
		else $error("power-on flag dropped without a clearing write");

	por_reset_a: assert property (@(posedge clk)
		reset |=> power_on_event_flag && input_selector_reg == adcsm_pkg::RST_INPUT_SELECTOR)
		else $error("reset defaults not restored");

	rail_gated_a: assert property (@(posedge clk) disable iff (reset)
		!rail_monitor_enable |=> rail_flags_reg == adcsm_pkg::RST_RAIL_FLAGS)
		else $error("rail flag raised while monitor disabled");

	rail_follows_a: assert property (@(posedge clk) disable iff (reset)
		rail_monitor_enable && pos_out_near_top_rail_raw ##1
		rail_monitor_enable && pos_out_near_top_rail_raw ##1
		rail_monitor_enable |=> rail_flags_reg[3])
		else $error("positive top rail flag missed a steady comparator");

	ref_gated_a: assert property (@(posedge clk) disable iff (reset)
		reference_monitor_enable == 2'h0 |=> ref_flags_reg == adcsm_pkg::RST_REF_FLAGS)
		else $error("reference flag raised while monitor disabled");

	status_snapshot_a: assert property (@(posedge clk) disable iff (reset)
		flags_read_s |=> rd_valid && rd_data == $past(condition_byte))
		else $error("condition read not a snapshot of the command edge");

	read_idle_a: assert property (@(posedge clk) disable iff (reset)
		!cmd_read |=> !rd_valid && rd_data == adcsm_pkg::RD_DATA_IDLE)
		else $error("read answer without a read command");

	selector_write_a: assert property (@(posedge clk) disable iff (reset)
		cmd_write && hit_selector |=> input_selector_reg == $past(cmd_wdata)
		&& positive_input_select
		== $past(cmd_wdata[adcsm_pkg::POS_SEL_MSB:adcsm_pkg::POS_SEL_LSB]))
		else $error("selector write not taken");

	six_channel_a: assert property (@(posedge clk) disable iff (reset)
		!twelve_ch && cmd_write && hit_selector && cmd_wdata[3:0] == 4'h6
		|=> !negative_select_valid)
		else $error("absent input reported valid on six-channel part");

	ready_high_a: assert property (@(posedge clk) disable iff (reset)
		startup_pending_raw ##2 1'b1 |=> condition_byte[adcsm_pkg::BIT_NOT_READY])
		else $error("not-ready bit missed a pending start-up");

	ready_low_a: assert property (@(posedge clk) disable iff (reset)
		!startup_pending_raw ##2 1'b1 |=> !condition_byte[adcsm_pkg::BIT_NOT_READY])
		else $error("not-ready bit set after start-up finished");

	pos_bottom_a: assert property (@(posedge clk) disable iff (reset)
		pos_out_near_bottom_rail_raw ##2 rail_monitor_enable |=> rail_flags_reg[2])
		else $error("positive bottom rail flag missed a comparator");

	neg_top_a: assert property (@(posedge clk) disable iff (reset)
		neg_out_near_top_rail_raw ##2 rail_monitor_enable |=> rail_flags_reg[1])
		else $error("negative top rail flag missed a comparator");

	neg_bottom_a: assert property (@(posedge clk) disable iff (reset)
		neg_out_near_bottom_rail_raw ##2 rail_monitor_enable |=> rail_flags_reg[0])
		else $error("negative bottom rail flag missed a comparator");

	rails_quiet_a: assert property (@(posedge clk) disable iff (reset)
		(!pos_out_near_top_rail_raw && !pos_out_near_bottom_rail_raw
		&& !neg_out_near_top_rail_raw && !neg_out_near_bottom_rail_raw) ##2 1'b1
		|=> rail_flags_reg == adcsm_pkg::RST_RAIL_FLAGS)
		else $error("rail flag raised with outputs clear of the rails");

	ref_third_a: assert property (@(posedge clk) disable iff (reset)
		reference_below_third_raw ##2 reference_monitor_enable[adcsm_pkg::REF_EN_THIRD_BIT]
		|=> condition_byte[adcsm_pkg::BIT_REF_THIRD])
		else $error("low reference flag missed a comparator");

	ref_third_low_a: assert property (@(posedge clk) disable iff (reset)
		!reference_below_third_raw ##2 1'b1 |=> !condition_byte[adcsm_pkg::BIT_REF_THIRD])
		else $error("low reference flag set with reference in range");

	ref_missing_a: assert property (@(posedge clk) disable iff (reset)
		reference_missing_raw ##2 (|reference_monitor_enable)
		|=> condition_byte[adcsm_pkg::BIT_REF_MISSING])
		else $error("missing reference flag missed a comparator");

	ref_missing_low_a: assert property (@(posedge clk) disable iff (reset)
		!reference_missing_raw ##2 1'b1 |=> !condition_byte[adcsm_pkg::BIT_REF_MISSING])
		else $error("missing reference flag set with reference present");

	neg_select_a: assert property (@(posedge clk) disable iff (reset)
		cmd_write && hit_selector |=> negative_input_select
		== $past(cmd_wdata[adcsm_pkg::NEG_SEL_MSB:adcsm_pkg::NEG_SEL_LSB]))
		else $error("negative select write not taken");

	twelve_channel_a: assert property (@(posedge clk) disable iff (reset)
		twelve_ch && cmd_write && hit_selector
		&& cmd_wdata[adcsm_pkg::NEG_SEL_MSB:adcsm_pkg::NEG_SEL_LSB]
		== adcsm_pkg::CODE_LAST_TWELVE |=> negative_select_valid)
		else $error("existing input reported invalid on twelve-channel part");

	reserved_code_a: assert property (@(posedge clk) disable iff (reset)
		cmd_write && hit_selector
		&& cmd_wdata[adcsm_pkg::POS_SEL_MSB:adcsm_pkg::POS_SEL_LSB] > adcsm_pkg::CODE_COMMON
		|=> !positive_select_valid)
		else $error("reserved code reported valid");

	selector_read_a: assert property (@(posedge clk) disable iff (reset)
		cmd_read && hit_selector |=> rd_valid && rd_data == $past(input_selector_reg))
		else $error("selector read did not return the register");

	status_write_a: assert property (@(posedge clk) disable iff (reset)
		cmd_write && hit_flags && !power_on_event_flag && !por_seen |=> !power_on_event_flag)
		else $error("power-on flag set by a register write");

endmodule : adcsm_regs

//--- tb/adcsm_host_model.sv
`timescale 1ns/1ps

module adcsm_host_model (
	input  wire logic                         clk,
	output logic                              cmd_read,
	output logic                              cmd_write,
	output logic      [adcsm_pkg::ADDR_W-1:0] cmd_addr,
	output logic      [adcsm_pkg::DATA_W-1:0] cmd_wdata,
	input  wire logic [adcsm_pkg::DATA_W-1:0] rd_data,
	input  wire logic                         rd_valid
);
	initial begin
		cmd_read = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 5'h00;
		cmd_wdata = 8'h00;
	end

	// idle lines show the inverse, so a stale address or byte cannot pass by luck
	task automatic idle_bus();
		cmd_read = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = ~cmd_addr;
		cmd_wdata = ~cmd_wdata;
	endtask : idle_bus

	// the only way in is a register command; a zero in bit 7 clears the flag
	task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		cmd_write = 1'b1;
		cmd_addr = a;
		cmd_wdata = d;
		@(posedge clk);
		#1;
		idle_bus();
	endtask : reg_write

	// answer is registered at the taking edge itself, so it is sampled 1 ns after that edge
	task automatic reg_read(input logic [4:0] a, output logic [7:0] d, output logic ok);
		@(posedge clk);
		#1;
		cmd_read = 1'b1;
		cmd_addr = a;
		@(posedge clk);
		#1;
		idle_bus();
		d = rd_data;
		ok = rd_valid;
	endtask : reg_read
endmodule : adcsm_host_model

//--- tb/tb.sv
`timescale 1ns/1ps

module tb;
	logic       clk, reset, cmd_read, cmd_write, rd_valid, ok;
	logic [4:0] cmd_addr;
	logic [7:0] cmd_wdata, rd_data, d;
	logic       rail_en, por_raw, strap, pos_v, neg_v, por_flag;
	logic [1:0] ref_en;
	logic [6:0] fault;
	logic [3:0] pos_sel, neg_sel;
	int         error_cnt, check_count;

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	adcsm_host_model u_host (.clk(clk), .cmd_read(cmd_read), .cmd_write(cmd_write),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));

	adcsm_regs u_dut (.clk(clk), .reset(reset), .cmd_read(cmd_read), .cmd_write(cmd_write),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
		.rail_monitor_enable(rail_en), .reference_monitor_enable(ref_en),
		.power_on_event_raw(por_raw), .startup_pending_raw(fault[6]),
		.pos_out_near_top_rail_raw(fault[5]), .pos_out_near_bottom_rail_raw(fault[4]),
		.neg_out_near_top_rail_raw(fault[3]), .neg_out_near_bottom_rail_raw(fault[2]),
		.reference_below_third_raw(fault[1]), .reference_missing_raw(fault[0]),
		.twelve_channel_strap(strap), .positive_input_select(pos_sel),
		.negative_input_select(neg_sel), .positive_select_valid(pos_v),
		.negative_select_valid(neg_v), .power_on_event_flag(por_flag));

	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string msg);
		u_host.reg_read(a, d, ok);
		chk({7'h00, ok}, 8'h01, "answer strobe");
		chk(d, exp, msg);
	endtask : rd_chk

	// synchroniser plus flag register need three edges; five leaves margin
	task automatic settle();
		repeat (5) @(posedge clk);
	endtask : settle

	function automatic logic vexp(input logic [3:0] c, input logic tw);
		return (c <= adcsm_pkg::CODE_LAST_SIX) || (c == adcsm_pkg::CODE_COMMON)
			|| (tw && c <= adcsm_pkg::CODE_LAST_TWELVE);
	endfunction : vexp

	initial begin
		#100000;
		error_cnt++;
		$display("wrong value at %0t: run did not complete", $time);
		end_of_test();
	end

	initial begin
		{reset, rail_en, ref_en, por_raw, strap, fault} = {1'b1, 12'h000};
		error_cnt = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		#1;
		reset = 1'b0;
		rd_chk(adcsm_pkg::ADDR_INPUT_SELECTOR, 8'h01, "selector default");
		chk({pos_sel, neg_sel}, 8'h01, "select outputs default");
		chk({7'h00, por_flag}, 8'h01, "power-on flag after reset");
		rd_chk(adcsm_pkg::ADDR_CONDITION_FLAGS, 8'h80, "flags default");
		u_host.reg_write(adcsm_pkg::ADDR_CONDITION_FLAGS, 8'hff);
		rd_chk(adcsm_pkg::ADDR_CONDITION_FLAGS, 8'h80, "writing one keeps flag");
		u_host.reg_write(adcsm_pkg::ADDR_CONDITION_FLAGS, 8'h7f);
		rd_chk(adcsm_pkg::ADDR_CONDITION_FLAGS, 8'h00, "flag cleared, rest ignored");
		u_host.reg_write(adcsm_pkg::ADDR_CONDITION_FLAGS, 8'hff);
		rd_chk(adcsm_pkg::ADDR_CONDITION_FLAGS, 8'h00, "writing one cannot set");
		por_raw = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		por_raw = 1'b0;
		settle();
		rd_chk(adcsm_pkg::ADDR_CONDITION_FLAGS, 8'h80, "power-on event sets flag");
		// a standing event must beat a clearing write at the same edge
		por_raw = 1'b1;
		settle();
		u_host.reg_write(adcsm_pkg::ADDR_CONDITION_FLAGS, 8'h00);
		chk({7'h00, por_flag}, 8'h01, "set wins over clear");
		por_raw = 1'b0;
		settle();
		u_host.reg_write(adcsm_pkg::ADDR_CONDITION_FLAGS, 8'h00);
		u_host.reg_read(5'h03, d, ok);
		chk({7'h00, ok}, 8'h00, "unmapped address answered");
		{rail_en, ref_en} = 3'h7;
		for (int i = 0; i < 7; i++) begin
			fault = 7'h01 << i;
			settle();
			rd_chk(adcsm_pkg::ADDR_CONDITION_FLAGS, 8'h01 << i,
				"single flag");
		end
		fault = 7'h3f;
		for (int r = 0; r < 8; r++) begin
			{rail_en, ref_en} = r[2:0];
			settle();
			rd_chk(adcsm_pkg::ADDR_CONDITION_FLAGS, {2'h0, {4{r[2]}}, r[1], r[1:0] != 2'h0},
				"monitor enables");
		end
		fault = 7'h00;
		for (int s = 0; s < 2; s++) begin
			strap = s[0];
			settle();
			for (int c = 0; c < 16; c++) begin
				u_host.reg_write(adcsm_pkg::ADDR_INPUT_SELECTOR, {c[3:0], ~c[3:0]});
				chk({pos_sel, neg_sel}, {c[3:0], ~c[3:0]}, "select outputs");
				chk({6'h00, pos_v, neg_v}, {6'h00, vexp(c[3:0], strap), vexp(~c[3:0], strap)},
					"select valid");
				rd_chk(adcsm_pkg::ADDR_INPUT_SELECTOR, {c[3:0], ~c[3:0]}, "selector");
			end
		end
		reset = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		reset = 1'b0;
		rd_chk(adcsm_pkg::ADDR_INPUT_SELECTOR, 8'h01, "selector after reset");
		rd_chk(adcsm_pkg::ADDR_CONDITION_FLAGS, 8'h80, "flags after reset");
		end_of_test();
	end
endmodule : tb
